// file: verification/ace_seq_model.sv
// sequencer side model: program counter and one-entry hardware stack
`timescale 1ns/1ps
module ace_seq_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic done,
    input wire logic stack_push,
    input wire logic [10:0] stack_data,
    input wire logic pc_load,
    input wire logic [10:0] pc_target,
    output logic [10:0] pc,
    output logic [10:0] stack_top
);
    // pc only moves at an instruction end, so it stays put while offered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc <= 11'h000;
            stack_top <= 11'h000;
        end else begin
            // push is a single pulse, taken as it stands
            if (stack_push) begin
                stack_top <= stack_data;
            end
            // a load wins over the plain step of the same edge
            if (pc_load) begin
                pc <= pc_target;
            end else if (done) begin
                pc <= pc + 11'h001;
            end
        end
    end
endmodule // ace_seq_model

// file: verification/add_and_call_execute_bench.sv
// self-checking bench for the add/and/call execute unit
`timescale 1ns/1ps
module add_and_call_execute_bench;
    logic clock = 1'b0; // 4 ns period
    logic rst_n = 1'b0; // reset, active low
    logic req_valid = 1'b0; // request offered
    ace_pkg::ace_req_t req = '0; // request fields
    logic [10:0] pc; // from the sequencer model
    logic req_ready, done, stack_push, pc_load;
    logic [7:0] working_register;
    ace_pkg::ace_flags_t flags;
    logic [10:0] stack_data, pc_target, stack_top;
    logic [7:0] exp_w; // expected working register
    ace_pkg::ace_flags_t exp_f; // expected flags
    logic [7:0] exp_mem [0:255]; // expected data bytes
    // corner list: op nibble, operand byte
    logic [11:0] corner [0:9] = '{12'h3FF, 12'h301, 12'h000, 12'h37F,
        12'h400, 12'h100, 12'h600, 12'h8FF, 12'h800, 12'hF55};
    int mismatches = 0;
    int tests_run = 0;

    always #2 clock = ~clock;

    ace_execute u_dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .pc(pc), .req_ready(req_ready), .done(done),
        .working_register(working_register), .flags(flags),
        .stack_push(stack_push), .stack_data(stack_data),
        .pc_load(pc_load), .pc_target(pc_target));
    ace_seq_model u_seq (.clock(clock), .rst_n(rst_n), .done(done),
        .stack_push(stack_push), .stack_data(stack_data),
        .pc_load(pc_load), .pc_target(pc_target), .pc(pc),
        .stack_top(stack_top));

    // one comparison, counted and reported on a miss
    task automatic check(input logic [31:0] got, input logic [31:0] want,
                         input string what);
        tests_run++;
        if (got !== want) begin
            mismatches++;
            $display("wrong value at %0t: %s %0h not %0h", $time, what,
                got, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // sum of a, b and carry in, with the four add flags
    function automatic ace_pkg::ace_flags_t add_flags(input logic [7:0] a,
            input logic [7:0] b, input logic cin, output logic [7:0] s);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        s = full[7:0];
        return {(a[7] == b[7]) && (s[7] != a[7]), s == 8'h00, low[4],
            full[8]};
    endfunction

    // one instruction: offer, time its pulses, then compare results
    task automatic run_op(input logic [3:0] op, input logic [7:0] opd,
                          input logic [7:0] adr, input logic [10:0] tgt);
        logic [7:0] s;
        logic [10:0] pc0;
        int push_at, load_at, done_at;
        push_at = 0;
        load_at = 0;
        done_at = 0;
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{ace_pkg::ace_op_t'(op), opd, adr, tgt};
        @(posedge clock);
        pc0 = pc;
        req_valid <= 1'b0;
        // bounded wait for done, noting when each pulse shows
        for (int k = 1; k <= 8 && done_at == 0; k++) begin
            @(posedge clock);
            #1;
            if (stack_push === 1'b1) push_at = k;
            if (pc_load === 1'b1) load_at = k;
            if (done === 1'b1) done_at = k;
        end
        case (op)
            // add family, carry used only by the two carry forms
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: begin
                exp_f = add_flags(exp_w, op == 4'h3 ? opd : exp_mem[adr],
                    op <= 4'h1 ? exp_f.carry_flag : 1'b0, s);
                if (op == 4'h1 || op == 4'h4) exp_mem[adr] = s;
                else exp_w = s;
            end
            // and family touches the zero flag alone
            4'h5, 4'h6, 4'h7: begin
                s = exp_w & (op == 4'h6 ? opd : exp_mem[adr]);
                exp_f.zero_flag = (s == 8'h00);
                if (op == 4'h7) exp_mem[adr] = s;
                else exp_w = s;
            end
            4'h9: exp_mem[adr] = 8'h00;
            default: ;
        endcase
        check(done_at, op == 4'h8 ? 3 : 1, "done cycle");
        check(push_at, op == 4'h8 ? 1 : 0, "push cycle");
        check(load_at, op == 4'h8 ? 3 : 0, "load cycle");
        @(posedge clock);
        #1;
        check(working_register, exp_w, "wreg");
        check(flags, exp_f, "flags");
        if (op == 4'h8) begin
            // return address wraps at the counter width, as on the core
            check(stack_top, 11'(pc0 + 11'h001), "stack");
            check(pc, tgt, "pc");
        end
    endtask

    // reset held 21 cycles, values checked, used bytes cleared
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (20) @(posedge clock);
        #1;
        check(working_register, 8'h00, "reset wreg");
        check(flags, 4'h0, "reset flags");
        check({req_ready, done}, 2'b10, "reset handshake");
        @(posedge clock);
        rst_n <= 1'b1;
        exp_w = 8'h00;
        exp_f = '0;
        for (int a = 0; a < 8; a++) begin
            run_op(4'h9, 8'h55, a[7:0], 11'h000);
        end
    endtask

    // random mix over eight bytes, so memory results get read back
    task automatic random_ops(input int n);
        for (int i = 0; i < n; i++) begin
            run_op(4'($urandom_range(0, 10)), 8'($urandom),
                8'($urandom_range(0, 7)), 11'($urandom));
        end
    endtask

    // hang guard, far beyond the expected run length
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(34979));
        do_reset();
        $display("reset test done");
        // carry, zero, overflow, wrap of pc, undefined code
        foreach (corner[k]) begin
            run_op(corner[k][11:8], corner[k][7:0], 8'h01,
                {corner[k][7:0], 3'h7});
        end
        $display("corner test done");
        random_ops(300);
        $display("random test done");
        do_reset();
        random_ops(100);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule // add_and_call_execute_bench

// file: verilog/ace_data_ram.sv
// data memory bytes with registered read port
`timescale 1ns/1ps
module ace_data_ram (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic write_en,
    input wire logic [7:0] write_addr,
    input wire logic [7:0] write_data,
    input wire logic [7:0] read_addr,
    output logic [7:0] read_data
);
    logic [7:0] cells [ace_pkg::ACE_DEPTH]; // storage, no reset
    logic [7:0] next_read_data; // value captured at next edge

    // read path; in its write cycle the caller reads the same byte but never uses that value
    always_comb begin
        next_read_data = cells[read_addr];
    end

    // array write, left unreset so it maps onto plain ram
    always_ff @(posedge clock) begin
        if (write_en) begin
            cells[write_addr] <= write_data;
        end
    end

    // read data register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            read_data <= ace_pkg::ACE_CLEAR_VALUE;
        end else begin
            read_data <= next_read_data;
        end
    end
endmodule // ace_data_ram

// file: verilog/ace_execute.sv
// execute unit for add, and, call and memory clear instructions
//
// Overview of operation
// - add with carry, result to working register
// - add with carry, result to memory
// - add memory byte to working register
// - add immediate to working register
// - add to memory, working register kept
// - and memory byte into working register
// - and immediate into working register, zero only
// - and into memory, working register kept
// - call pushes program counter plus one
// - call loads target, flags unchanged
// - call always takes two instruction cycles
// - clear writes zero byte, flags kept
// - and to working register: one cycle
`timescale 1ns/1ps
module ace_execute (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire ace_pkg::ace_req_t req,
    input wire logic [10:0] pc,
    output logic req_ready,
    output logic done,
    output logic [7:0] working_register,
    output ace_pkg::ace_flags_t flags,
    output logic stack_push,
    output logic [10:0] stack_data,
    output logic pc_load,
    output logic [10:0] pc_target
);
    ace_pkg::ace_state_t state; // sequencer state
    ace_pkg::ace_state_t next_state;
    ace_pkg::ace_req_t req_q; // request held through execution
    ace_pkg::ace_req_t next_req_q;
    logic [10:0] next_stack_data;
    logic [10:0] next_pc_target;
    logic [7:0] next_working_register;
    ace_pkg::ace_flags_t next_flags;
    logic accept; // request taken this edge
    logic in_exec; // execute phase of an instruction cycle
    logic is_add; // add family
    logic is_and; // and family
    logic use_imm; // operand from instruction
    logic use_cin; // carry flag joins the sum
    logic to_mem; // result back to data memory
    logic [7:0] operand_b; // second operand
    logic cin; // carry in
    logic [8:0] wide_sum; // sum with carry out
    logic [4:0] half_sum; // low nibble sum with carry out
    logic [7:0] and_result;
    logic mem_we; // data memory write strobe
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata; // byte at req_q.addr, one clock after READ

    // an instruction cycle is two clocks: READ fetches, EXEC writes
    ace_data_ram u_ram (
        .clock(clock),
        .rst_n(rst_n),
        .write_en(mem_we),
        .write_addr(req_q.addr),
        .write_data(mem_wdata),
        .read_addr(req_q.addr),
        .read_data(mem_rdata)
    );

    assign req_ready = (state == ace_pkg::ACE_IDLE);
    assign accept = req_valid && req_ready;
    assign in_exec = (state == ace_pkg::ACE_EXEC);

    // decode of the held opcode
    always_comb begin
        is_add = 1'b0;
        is_and = 1'b0;
        use_imm = 1'b0;
        use_cin = 1'b0;
        to_mem = 1'b0;
        case (req_q.op)
            ace_pkg::ACE_OP_ADD_CARRY_TO_WREG: begin
                is_add = 1'b1;
                use_cin = 1'b1;
            end
            ace_pkg::ACE_OP_ADD_WITH_CARRY_TO_MEMORY: begin
                is_add = 1'b1;
                use_cin = 1'b1;
                to_mem = 1'b1;
            end
            ace_pkg::ACE_OP_ADD_MEM_TO_WREG: begin
                is_add = 1'b1;
            end
            ace_pkg::ACE_OP_ADD_IMM_TO_WREG: begin
                is_add = 1'b1;
                use_imm = 1'b1;
            end
            ace_pkg::ACE_OP_ADD_TO_MEMORY: begin
                is_add = 1'b1;
                to_mem = 1'b1;
            end
            ace_pkg::ACE_OP_AND_MEM_TO_WREG: begin
                is_and = 1'b1;
            end
            ace_pkg::ACE_OP_AND_IMM_TO_WREG: begin
                is_and = 1'b1;
                use_imm = 1'b1;
            end
            ace_pkg::ACE_OP_BITWISE_AND_TO_MEMORY: begin
                is_and = 1'b1;
                to_mem = 1'b1;
            end
            ace_pkg::ACE_OP_CLEAR_MEMORY: begin
                to_mem = 1'b1;
            end
            default: begin
                // call and unused codes touch no data
            end
        endcase
    end

    // arithmetic; nine-bit sum so wrap and carry fall out together
    always_comb begin
        operand_b = use_imm ? req_q.operand : mem_rdata;
        cin = use_cin & flags.carry_flag;
        wide_sum = {1'b0, working_register} + {1'b0, operand_b}
            + {8'h00, cin};
        half_sum = {1'b0, working_register[3:0]} + {1'b0, operand_b[3:0]}
            + {4'h0, cin};
        and_result = working_register & operand_b;
    end

    // result steering and flag update during the execute phase
    always_comb begin
        next_working_register = working_register;
        next_flags = flags;
        mem_we = 1'b0;
        mem_wdata = ace_pkg::ACE_CLEAR_VALUE;
        if (in_exec) begin
            if (is_add) begin
                mem_wdata = wide_sum[7:0];
                next_flags.carry_flag =
                    wide_sum[ace_pkg::ACE_CARRY_BIT];
                next_flags.half_carry_flag =
                    half_sum[ace_pkg::ACE_HALF_BIT];
                next_flags.signed_overflow_flag =
                    (working_register[ace_pkg::ACE_SIGN_BIT] ==
                     operand_b[ace_pkg::ACE_SIGN_BIT]) &&
                    (wide_sum[ace_pkg::ACE_SIGN_BIT] !=
                     working_register[ace_pkg::ACE_SIGN_BIT]);
                next_flags.zero_flag = (wide_sum[7:0] == 8'h00);
            end else if (is_and) begin
                // only zero moves; other flags held on purpose
                mem_wdata = and_result;
                next_flags.zero_flag = (and_result == 8'h00);
            end
            if (to_mem) begin
                mem_we = 1'b1;
            end else if (is_add || is_and) begin
                next_working_register = mem_wdata;
            end
        end
    end

    // sequencer; call adds a second instruction cycle
    always_comb begin
        next_state = state;
        next_req_q = req_q;
        next_stack_data = stack_data;
        next_pc_target = pc_target;
        case (state)
            ace_pkg::ACE_IDLE: begin
                if (accept) begin
                    next_req_q = req;
                    next_stack_data = pc + ace_pkg::ACE_PC_STEP;
                    next_pc_target = req.target;
                    next_state = ace_pkg::ACE_READ;
                end
            end
            ace_pkg::ACE_READ: begin
                next_state = ace_pkg::ACE_EXEC;
            end
            ace_pkg::ACE_EXEC: begin
                if (req_q.op == ace_pkg::ACE_OP_CALL) begin
                    next_state = ace_pkg::ACE_CALL1;
                end else begin
                    next_state = ace_pkg::ACE_IDLE;
                end
            end
            ace_pkg::ACE_CALL1: begin
                next_state = ace_pkg::ACE_CALL2;
            end
            ace_pkg::ACE_CALL2: begin
                next_state = ace_pkg::ACE_IDLE;
            end
            default: begin
                // illegal code recovers to idle
                next_state = ace_pkg::ACE_IDLE;
            end
        endcase
    end

    // push in the first cycle, jump at the end of the second
    assign stack_push = in_exec && (req_q.op == ace_pkg::ACE_OP_CALL);
    assign pc_load = (state == ace_pkg::ACE_CALL2);
    assign done = (in_exec && (req_q.op != ace_pkg::ACE_OP_CALL)) || pc_load;

    // state registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ace_pkg::ACE_IDLE;
            req_q <= '0;
            stack_data <= ace_pkg::ACE_PC_RST;
            pc_target <= ace_pkg::ACE_PC_RST;
            working_register <= ace_pkg::ACE_WREG_RST;
            flags <= ace_pkg::ACE_FLAGS_RST;
        end else begin
            state <= next_state;
            req_q <= next_req_q;
            stack_data <= next_stack_data;
            pc_target <= next_pc_target;
            working_register <= next_working_register;
            flags <= next_flags;
        end
    end

    // checks on the sequencing and datapath
    default clocking dcb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_call_taken;
        accept && (req.op == ace_pkg::ACE_OP_CALL);
    endsequence
    sequence s_call_body;
        ##2 stack_push ##2 (pc_load && done);
    endsequence

    a_call_two_cycles: assert property (
        s_call_taken |-> s_call_body)
        else $error("call did not finish in two instruction cycles");
    a_call_push_value: assert property (s_call_taken |->
        ##2 (stack_data == $past(pc, 2) + ace_pkg::ACE_PC_STEP))
        else $error("return address is not pc plus one");
    a_call_target: assert property (s_call_taken |->
        ##4 (pc_target == $past(req.target, 4)))
        else $error("call target not loaded");
    a_call_flags_keep: assert property (s_call_taken |=>
        $stable(flags)[*4])
        else $error("flags changed during call");
    a_and_zero_only: assert property (in_exec && is_and |=>
        ($stable(flags.carry_flag) && $stable(flags.half_carry_flag) &&
         $stable(flags.signed_overflow_flag) &&
         (flags.zero_flag == ($past(and_result) == 8'h00))))
        else $error("and changed a flag other than zero");
    a_add_imm_sum: assert property (in_exec &&
        (req_q.op == ace_pkg::ACE_OP_ADD_IMM_TO_WREG) |=>
        (working_register == 8'($past(working_register) +
         $past(req_q.operand))))
        else $error("immediate add result wrong");
    a_add_carry_out: assert property (in_exec && is_add |=>
        (flags.carry_flag == ($past({2'b00, working_register} +
         {2'b00, operand_b} + {9'h000, cin}) > 10'h0FF)))
        else $error("add carry flag wrong");
    a_mem_dest_keep: assert property (in_exec && to_mem |->
        mem_we ##1 $stable(working_register))
        else $error("memory-destination op changed working register");
    a_clear_zero: assert property (in_exec &&
        (req_q.op == ace_pkg::ACE_OP_CLEAR_MEMORY) |->
        (mem_we && (mem_wdata == 8'h00)) ##1 $stable(flags))
        else $error("clear did not write zero or moved flags");
    a_and_one_cycle: assert property (accept &&
        ((req.op == ace_pkg::ACE_OP_AND_MEM_TO_WREG) ||
         (req.op == ace_pkg::ACE_OP_AND_IMM_TO_WREG)) |->
        ##2 done ##1 req_ready)
        else $error("and to working register not single cycle");
endmodule // ace_execute

// file: verilog/ace_pkg.sv
// constants and types shared by the add/and/call execute block
package ace_pkg;
    localparam int ACE_DW = 8; // data byte width
    localparam int ACE_AW = 8; // data memory address width
    localparam int ACE_PCW = 11; // program counter width
    localparam int ACE_DEPTH = 256; // data memory bytes
    localparam logic [7:0] ACE_WREG_RST = 8'h00; // working register reset
    localparam logic [7:0] ACE_CLEAR_VALUE = 8'h00; // memory clear pattern
    localparam logic [10:0] ACE_PC_STEP = 11'h001; // return address step
    localparam logic [10:0] ACE_PC_RST = 11'h000; // stack/target reset
    localparam int ACE_HALF_BIT = 4; // carry out of bit 3 lands here
    localparam int ACE_SIGN_BIT = 7; // two's-complement sign
    localparam int ACE_CARRY_BIT = 8; // carry out of bit 7 lands here

    // instruction codes presented by the decoder
    typedef enum logic [3:0] {
        ACE_OP_ADD_CARRY_TO_WREG = 4'h0,
        ACE_OP_ADD_WITH_CARRY_TO_MEMORY = 4'h1,
        ACE_OP_ADD_MEM_TO_WREG = 4'h2,
        ACE_OP_ADD_IMM_TO_WREG = 4'h3,
        ACE_OP_ADD_TO_MEMORY = 4'h4,
        ACE_OP_AND_MEM_TO_WREG = 4'h5,
        ACE_OP_AND_IMM_TO_WREG = 4'h6,
        ACE_OP_BITWISE_AND_TO_MEMORY = 4'h7,
        ACE_OP_CALL = 4'h8,
        ACE_OP_CLEAR_MEMORY = 4'h9
    } ace_op_t;

    // one request from the decoder
    typedef struct packed {
        ace_op_t op;
        logic [7:0] operand; // immediate data
        logic [7:0] addr; // data memory address
        logic [10:0] target; // call target
    } ace_req_t;

    // status flags touched by this block
    typedef struct packed {
        logic signed_overflow_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } ace_flags_t;

    localparam ace_flags_t ACE_FLAGS_RST = 4'h0; // flags after reset

    // one-hot sequencer states
    typedef enum logic [4:0] {
        ACE_IDLE = 5'b00001,
        ACE_READ = 5'b00010,
        ACE_EXEC = 5'b00100,
        ACE_CALL1 = 5'b01000,
        ACE_CALL2 = 5'b10000
    } ace_state_t;
endpackage
